/* File: src/eag_core.sv */
/*
  Effective address generator with an AXI4-Lite register slave.
  Assumes one 100 MHz clock, synchronous active-low reset, a master that
  keeps AXI4-Lite handshake rules.
*/
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Stack and code references take no override
// - String store/move destination always extra segment
// - Data defaults data segment; frame/stack base stack
// - Linear address is segment base plus offset
// - Offset sums displacement, base, scaled index
// - Displacement is 8, 16 or 32 bits
// - Index excludes stack pointer; scale 1,2,4,8
// - Six memory addressing forms supported
// - Base plus index costs one extra clock
// - Register and immediate operands also supported
// - Protected size follows descriptor size flag
// - Real mode defaults to 16-bit sizes
// - Length prefixes invert defaults per instruction
// - Real mode offset over 64K faults
// - 32-bit addressing: any base; any index except stack pointer
// - 16-bit addressing: word base/index, no scaling
// - Bit field at most 32 bits, four bytes
// - Signed operands use two's complement
// - Packed and unpacked decimal digit checks
// - Far pointer is selector plus offset at 16-bit operand size only
// - Real mode segment base is selector shifted four
module eag_core #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  generate
    if (ADDR_W < 8) begin : g_chk
      $error("ADDR_W too small for register map");
    end
  endgenerate

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] disp;
    logic [31:0] dtype;
    logic [7:0][31:0] gpr;
    logic [5:0][31:0] seg;
    eag_pkg::eag_phase_type phase;
    logic done;
    logic fault;
    logic op32;
    logic ad32;
    logic [2:0] seg_used;
    logic [31:0] offset;
    logic [31:0] linear;
    logic [31:0] operand;
  } eag_state_type;

  eag_state_type q;
  eag_state_type n;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Returns {hit, class[1:0], index[2:0]}; class 0 single, 1 gpr, 2 seg
  function automatic logic [5:0] eag_decode(input logic [ADDR_W-1:0] a);
    logic [6:0] w;
    w = a[6:0];
    eag_decode = 6'h00;
    if (a[1:0] == 2'h0 && a[ADDR_W-1:7] == '0) begin
      if (w >= eag_pkg::OFF_SEG && w < 7'h58) begin
        eag_decode = {3'h6, 3'(w[4:2] - 3'h0)};
      end else if (w >= eag_pkg::OFF_GPR && w < eag_pkg::OFF_SEG) begin
        eag_decode = {3'h5, w[4:2]};
      end else if (w <= eag_pkg::OFF_OPERAND) begin
        eag_decode = {3'h4, w[4:2]};
      end
    end
  endfunction

  function automatic logic [31:0] eag_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      eag_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Address path
  // ----------------------------------------------------------------
  logic real_m;
  logic ad32_c;
  logic op32_c;
  logic [2:0] kind;
  logic [2:0] base_r;
  logic [2:0] idx_r;
  logic [31:0] base_v;
  logic [31:0] idx_v;
  logic [31:0] disp_v;
  logic [31:0] sum_c;
  logic [31:0] off_c;
  logic fault_c;
  logic stack_base;
  logic [2:0] seg_c;
  logic [31:0] segbase_c;
  logic [31:0] lin_c;
  logic [31:0] src_v;
  logic [31:0] opnd_c;
  logic [5:0] bf_w;
  logic [6:0] bf_end;
  logic bf_ok;
  logic [7:0] bcd;
  logic [31:0] status_c;

  assign real_m = q.ctrl[eag_pkg::C_REAL];
  assign kind = q.ctrl[eag_pkg::C_KIND +: 3];
  assign base_r = q.ctrl[eag_pkg::C_BASE +: 3];
  assign idx_r = q.ctrl[eag_pkg::C_IDX +: 3];
  assign ad32_c = (real_m ? 1'b0 : q.ctrl[eag_pkg::C_DFLAG]) ^
                  q.ctrl[eag_pkg::C_APFX];
  assign op32_c = (real_m ? 1'b0 : q.ctrl[eag_pkg::C_DFLAG]) ^
                  q.ctrl[eag_pkg::C_OPFX];

  always_comb begin
    base_v = 32'h0000_0000;
    idx_v = 32'h0000_0000;
    if (ad32_c) begin
      if (q.ctrl[eag_pkg::C_BASE_EN]) begin
        base_v = q.gpr[base_r];
      end
      if (q.ctrl[eag_pkg::C_IDX_EN] && idx_r != eag_pkg::REG_STACK) begin
        idx_v = q.gpr[idx_r] << q.ctrl[eag_pkg::C_SCALE +: 2];
      end
    end else begin
      // Word base picks base or frame word; index picks source or dest
      if (q.ctrl[eag_pkg::C_BASE_EN]) begin
        base_v = {16'h0000, q.gpr[base_r[0] ? 3'h5 : 3'h3][15:0]};
      end
      if (q.ctrl[eag_pkg::C_IDX_EN]) begin
        idx_v = {16'h0000, q.gpr[idx_r[0] ? 3'h7 : 3'h6][15:0]};
      end
    end
    case (q.ctrl[eag_pkg::C_DSZ +: 2])
      eag_pkg::DSZ_BYTE: disp_v = {{24{q.disp[7]}}, q.disp[7:0]};
      eag_pkg::DSZ_FULL: disp_v = ad32_c ? q.disp : {{16{q.disp[15]}}, q.disp[15:0]};
      default: disp_v = 32'h0000_0000;
    endcase
  end

  assign sum_c = base_v + idx_v + disp_v;
  assign off_c = ad32_c ? sum_c : {16'h0000, sum_c[15:0]};
  assign fault_c = real_m && off_c > eag_pkg::REAL_LIMIT;

  assign stack_base = q.ctrl[eag_pkg::C_BASE_EN] &&
                      (ad32_c ? (base_r == eag_pkg::REG_FRAME || base_r == eag_pkg::REG_STACK)
                              : base_r[0]);
  always_comb begin
    case (kind)
      eag_pkg::KIND_FETCH: seg_c = eag_pkg::SEG_CODE;
      eag_pkg::KIND_PUSH, eag_pkg::KIND_POP: seg_c = eag_pkg::SEG_STACK;
      eag_pkg::KIND_STR_DST: seg_c = eag_pkg::SEG_EXTRA;
      default: begin
        seg_c = stack_base ? eag_pkg::SEG_STACK : eag_pkg::SEG_DATA;
        if (q.ctrl[eag_pkg::C_OVR_EN] && q.ctrl[eag_pkg::C_OVR +: 3] <= eag_pkg::SEG_AUX2) begin
          seg_c = q.ctrl[eag_pkg::C_OVR +: 3];
        end
      end
    endcase
  end

  assign segbase_c = real_m ? {12'h000, q.seg[seg_c][15:0], 4'h0} : q.seg[seg_c];
  assign lin_c = segbase_c + off_c;

  // Register or immediate operand, sized and extended
  assign src_v = q.ctrl[eag_pkg::C_OPM +: 2] == eag_pkg::OPM_IMM ? q.disp : q.gpr[base_r];
  always_comb begin
    if (q.ctrl[eag_pkg::C_OPM +: 2] == eag_pkg::OPM_MEM) begin
      if (q.ctrl[eag_pkg::C_FAR] && !op32_c) begin
        opnd_c = {q.seg[seg_c][15:0], off_c[15:0]};
      end else begin
        opnd_c = op32_c ? off_c : {16'h0000, off_c[15:0]};
      end
    end else if (q.ctrl[eag_pkg::C_BYTE]) begin
      opnd_c = {{24{q.ctrl[eag_pkg::C_SIGNED] & src_v[7]}}, src_v[7:0]};
    end else if (!op32_c) begin
      opnd_c = {{16{q.ctrl[eag_pkg::C_SIGNED] & src_v[15]}}, src_v[15:0]};
    end else begin
      opnd_c = src_v;
    end
  end

  // Data type checks
  assign bf_w = q.dtype[5:0];
  assign bf_end = {1'b0, bf_w} + {4'h0, q.dtype[10:8]};
  assign bf_ok = bf_w != 6'h00 && bf_w <= 6'h20 && bf_end <= 7'h20;
  assign bcd = q.dtype[23:16];
  assign status_c = {21'h0, bcd <= 8'h09, bcd[7:4] <= 4'h9 && bcd[3:0] <= 4'h9,
                     bf_ok, q.seg_used, q.ad32, q.op32, q.fault, q.done,
                     q.phase != eag_pkg::EAG_IDLE};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [5:0] wdec;
  logic [5:0] rdec;
  logic wr_go;
  logic rd_go;
  logic [31:0] wval;
  logic start_go;

  assign wdec = eag_decode(s_axi_awaddr);
  assign rdec = eag_decode(s_axi_araddr);
  assign wr_go = q.awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_go = q.arready && s_axi_arvalid;

  always_comb begin
    n = q;
    wval = 32'h0000_0000;
    start_go = 1'b0;
    // Address and data are taken together, one beat per response
    n.awready = !q.awready && !q.bvalid && s_axi_awvalid && s_axi_wvalid;
    n.wready = !q.awready && !q.bvalid && s_axi_awvalid && s_axi_wvalid;
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp = eag_pkg::RESP_OKAY;
      case (wdec)
        6'h20: begin
          wval = eag_merge(q.ctrl, s_axi_wdata, s_axi_wstrb);
          // Control is frozen while a calculation runs
          if (q.phase == eag_pkg::EAG_IDLE) begin
            n.ctrl = {wval[31:1], 1'b0};
            start_go = wval[eag_pkg::C_START];
          end
        end
        6'h21: n.disp = eag_merge(q.disp, s_axi_wdata, s_axi_wstrb);
        6'h22: n.dtype = eag_merge(q.dtype, s_axi_wdata, s_axi_wstrb);
        6'h23, 6'h24, 6'h25, 6'h26: begin
        end
        default: begin
          if (wdec[5:3] == 3'h5) begin
            n.gpr[wdec[2:0]] = eag_merge(q.gpr[wdec[2:0]], s_axi_wdata, s_axi_wstrb);
          end else if (wdec[5:3] == 3'h6 && wdec[2:0] <= eag_pkg::SEG_AUX2) begin
            n.seg[wdec[2:0]] = eag_merge(q.seg[wdec[2:0]], s_axi_wdata, s_axi_wstrb);
          end else begin
            n.bresp = eag_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    n.arready = !q.arready && !q.rvalid && s_axi_arvalid;
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp = eag_pkg::RESP_OKAY;
      case (rdec)
        6'h20: n.rdata = q.ctrl;
        6'h21: n.rdata = q.disp;
        6'h22: n.rdata = q.dtype;
        6'h23: n.rdata = status_c;
        6'h24: n.rdata = q.offset;
        6'h25: n.rdata = q.linear;
        6'h26: n.rdata = q.operand;
        default: begin
          if (rdec[5:3] == 3'h5) begin
            n.rdata = q.gpr[rdec[2:0]];
          end else if (rdec[5:3] == 3'h6 && rdec[2:0] <= eag_pkg::SEG_AUX2) begin
            n.rdata = q.seg[rdec[2:0]];
          end else begin
            n.rdata = eag_pkg::RESET_WORD;
            n.rresp = eag_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    // Calculation sequencer
    case (q.phase)
      eag_pkg::EAG_IDLE: begin
        if (start_go) begin
          n.done = 1'b0;
          n.fault = 1'b0;
          if (wval[eag_pkg::C_BASE_EN] && wval[eag_pkg::C_IDX_EN] &&
              wval[eag_pkg::C_OPM +: 2] == eag_pkg::OPM_MEM) begin
            n.phase = eag_pkg::EAG_WAIT;
          end else begin
            n.phase = eag_pkg::EAG_CALC;
          end
        end
      end
      eag_pkg::EAG_WAIT: n.phase = eag_pkg::EAG_CALC;
      eag_pkg::EAG_CALC: begin
        n.phase = eag_pkg::EAG_IDLE;
        n.done = 1'b1;
        n.op32 = op32_c;
        n.ad32 = ad32_c;
        n.seg_used = seg_c;
        n.offset = off_c;
        n.operand = opnd_c;
        if (q.ctrl[eag_pkg::C_OPM +: 2] == eag_pkg::OPM_MEM) begin
          n.fault = fault_c;
          n.linear = fault_c ? eag_pkg::RESET_WORD : lin_c;
        end
      end
      default: n.phase = eag_pkg::EAG_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic calc_now;
  assign calc_now = q.phase == eag_pkg::EAG_CALC;

  fetch_seg_a: assert property (calc_now && kind == eag_pkg::KIND_FETCH |=>
    q.seg_used == eag_pkg::SEG_CODE) else $error("fetch not in code segment");
  string_dst_a: assert property (calc_now && kind == eag_pkg::KIND_STR_DST |=>
    q.seg_used == eag_pkg::SEG_EXTRA) else $error("string destination not extra segment");
  frame_default_a: assert property (calc_now && kind == 3'h4 && stack_base &&
    !q.ctrl[eag_pkg::C_OVR_EN] |=> q.seg_used == eag_pkg::SEG_STACK)
    else $error("frame base not stack segment");
  linear_sum_a: assert property ($rose(q.done) && !q.fault &&
    q.ctrl[eag_pkg::C_OPM +: 2] == eag_pkg::OPM_MEM |-> q.linear ==
    (real_m ? {12'h000, q.seg[q.seg_used][15:0], 4'h0} : q.seg[q.seg_used]) + q.offset)
    else $error("linear address mismatch");
  two_step_a: assert property (start_go && n.phase == eag_pkg::EAG_WAIT |=>
    !q.done [*2] ##1 q.done) else $error("base plus index latency wrong");
  one_step_a: assert property (start_go && n.phase == eag_pkg::EAG_CALC |=>
    !q.done ##1 q.done) else $error("single component latency wrong");
  real_size_a: assert property ($rose(q.done) && $past(real_m) &&
    !$past(q.ctrl[eag_pkg::C_APFX]) |-> !q.ad32 && q.offset[31:16] == 16'h0000)
    else $error("real mode size not 16 bits");
  prefix_flip_a: assert property (calc_now && !real_m |=> q.op32 ==
    ($past(q.ctrl[eag_pkg::C_DFLAG]) ^ $past(q.ctrl[eag_pkg::C_OPFX])))
    else $error("operand size prefix wrong");
  real_fault_a: assert property ($rose(q.done) && $past(real_m) &&
    $past(q.ctrl[eag_pkg::C_OPM +: 2]) == eag_pkg::OPM_MEM |->
    q.fault == (q.offset > eag_pkg::REAL_LIMIT)) else $error("real mode limit fault wrong");
  no_sp_index_a: assert property (calc_now && ad32_c && !q.ctrl[eag_pkg::C_BASE_EN] &&
    q.ctrl[eag_pkg::C_IDX_EN] && idx_r == eag_pkg::REG_STACK &&
    q.ctrl[eag_pkg::C_DSZ +: 2] == 2'h0 |=> q.offset == 32'h0000_0000)
    else $error("stack pointer used as index");

  wait_path_c: cover property (q.phase == eag_pkg::EAG_WAIT ##1 calc_now ##1 q.done);
  fault_seen_c: cover property ($rose(q.fault));
  override_c: cover property (calc_now && q.ctrl[eag_pkg::C_OVR_EN] && kind == 3'h4);
  write_read_c: cover property (q.bvalid ##[1:4] q.rvalid);
endmodule
`default_nettype wire

/* File: shared/eag_pkg.sv */
/*
  Constants for the effective address generator: register map, field
  positions, segment and reference codes, reset values.
  Assumes a 32-bit AXI4-Lite register bus and one synchronous clock.
*/
package eag_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] OFF_CTRL = 7'h00;
  localparam logic [6:0] OFF_DISP = 7'h04;
  localparam logic [6:0] OFF_DTYPE = 7'h08;
  localparam logic [6:0] OFF_STATUS = 7'h0c;
  localparam logic [6:0] OFF_OFFSET = 7'h10;
  localparam logic [6:0] OFF_LINEAR = 7'h14;
  localparam logic [6:0] OFF_OPERAND = 7'h18;
  localparam logic [6:0] OFF_GPR = 7'h20;
  localparam logic [6:0] OFF_SEG = 7'h40;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int C_START = 0;
  localparam int C_REAL = 1;
  localparam int C_DFLAG = 2;
  localparam int C_OPFX = 3;
  localparam int C_APFX = 4;
  localparam int C_KIND = 5;
  localparam int C_OVR_EN = 8;
  localparam int C_OVR = 9;
  localparam int C_BASE_EN = 12;
  localparam int C_BASE = 13;
  localparam int C_IDX_EN = 16;
  localparam int C_IDX = 17;
  localparam int C_SCALE = 20;
  localparam int C_DSZ = 22;
  localparam int C_OPM = 24;
  localparam int C_BYTE = 26;
  localparam int C_SIGNED = 28;
  localparam int C_FAR = 29;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEG_EXTRA = 3'h0;
  localparam logic [2:0] SEG_CODE = 3'h1;
  localparam logic [2:0] SEG_STACK = 3'h2;
  localparam logic [2:0] SEG_DATA = 3'h3;
  localparam logic [2:0] SEG_AUX1 = 3'h4;
  localparam logic [2:0] SEG_AUX2 = 3'h5;
  localparam logic [2:0] KIND_FETCH = 3'h0;
  localparam logic [2:0] KIND_PUSH = 3'h1;
  localparam logic [2:0] KIND_POP = 3'h2;
  localparam logic [2:0] KIND_STR_DST = 3'h3;
  localparam logic [1:0] OPM_MEM = 2'h0;
  localparam logic [1:0] OPM_REG = 2'h1;
  localparam logic [1:0] OPM_IMM = 2'h2;
  localparam logic [1:0] DSZ_BYTE = 2'h1;
  localparam logic [1:0] DSZ_FULL = 2'h2;
  localparam logic [2:0] REG_STACK = 3'h4;
  localparam logic [2:0] REG_FRAME = 3'h5;
  localparam logic [31:0] REAL_LIMIT = 32'h0000_ffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {EAG_IDLE, EAG_WAIT, EAG_CALC} eag_phase_type;
endpackage

/* File: verif/eag_core_tb.sv */
/*
  Self-checking bench for eag_core: AXI4-Lite read and write tasks and
  address calculations compared with values worked out here.
  Assumes the eag_pkg register map, a 100 MHz clock and no other master.
*/
`timescale 1ns/1ps
`default_nettype none
module eag_core_tb;
  localparam logic [7:0] A_ST = 8'(eag_pkg::OFF_STATUS);
  localparam logic [1:0] OK = eag_pkg::RESP_OKAY;
  localparam logic [31:0] OPREG = 32'(eag_pkg::OPM_REG) << eag_pkg::C_OPM;
  localparam logic [31:0] OPIMM = 32'(eag_pkg::OPM_IMM) << eag_pkg::C_OPM;
  localparam logic [31:0] BYT = 32'h1 << eag_pkg::C_BYTE;
  localparam logic [31:0] SGN = 32'h1 << eag_pkg::C_SIGNED;
  localparam logic [31:0] FAR = 32'h1 << eag_pkg::C_FAR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] ws = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd, e, c;
  logic [31:0] g [8];
  logic [31:0] sg [6];
  logic [31:0] dt [4] = '{32'h0099_0020, 32'h0009_0120, 32'h009a_0719, 32'h0000_0021};
  logic [2:0] dx [4] = '{3'b011, 3'b110, 3'b001, 3'b110};
  int err_total = 0;
  int checked = 0;

  always #5 clk = ~clk;

  eag_core #(.ADDR_W(8)) u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // --------------------------------------------------------------
  // Bus, check and report tasks
  // --------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    checked++;
    if (y !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] xr);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= ws;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(xr), 32'(bresp));
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    rdr(a, rd, rs);
    chk(nm, x, rd);
    chk("rresp", 32'(OK), 32'(rs));
  endtask

  function automatic logic [31:0] cw(input logic [3:0] md, input logic [2:0] k,
    input logic [3:0] ov, input logic [3:0] b, input logic [3:0] x, input logic [1:0] sc,
    input logic [1:0] ds);
    return (32'(md) << eag_pkg::C_REAL) | (32'(k) << eag_pkg::C_KIND)
      | (32'(ov) << eag_pkg::C_OVR_EN) | (32'(b) << eag_pkg::C_BASE_EN)
      | (32'(x) << eag_pkg::C_IDX_EN) | (32'(sc) << eag_pkg::C_SCALE)
      | (32'(ds) << eag_pkg::C_DSZ);
  endfunction

  // Start one calculation, wait for done, compare results
  task automatic run(input logic [31:0] cc, input logic [31:0] d, input logic [31:0] off,
    input logic [2:0] s, input logic [31:0] op, input logic [1:0] m);
    logic r, a, o, f;
    logic [31:0] bs;
    int n;
    r = cc[eag_pkg::C_REAL];
    a = (!r & cc[eag_pkg::C_DFLAG]) ^ cc[eag_pkg::C_APFX];
    o = (!r & cc[eag_pkg::C_DFLAG]) ^ cc[eag_pkg::C_OPFX];
    f = r & a & (off > 32'hffff);
    bs = r ? {12'h0, sg[s][15:0], 4'h0} : sg[s];
    wr(8'(eag_pkg::OFF_DISP), d, OK);
    wr(8'(eag_pkg::OFF_CTRL), cc | 32'h1, OK);
    n = 0;
    do begin
      rdr(A_ST, rd, rs);
      n++;
    end while (rd[1] !== 1'b1 && n < 20);
    chk("done", 32'h2, rd & 32'h2);
    if (m[0]) begin
      chk("status", {24'h0, s, a, o, f, 2'b10}, rd & 32'hff);
      rchk(8'(eag_pkg::OFF_OFFSET), off, "offset");
      rchk(8'(eag_pkg::OFF_LINEAR), f ? 32'h0 : bs + off, "linear");
    end
    if (m[1]) rchk(8'(eag_pkg::OFF_OPERAND), op, "operand");
  endtask

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) g[i] = 32'h0101_0000 * 32'(i + 1) + 32'h1111 * 32'(i);
    g[7] = 32'hfedc_ba9c;
    for (int s = 0; s < 6; s++) sg[s] = 32'h2000_1230 + 32'h0100_0101 * 32'(s);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdr(A_ST, rd, rs);
    chk("status reset", 32'h0, rd & 32'hff);
    rchk(8'(eag_pkg::OFF_OFFSET), eag_pkg::RESET_WORD, "offset reset");
    rdr(8'h1c, rd, rs);
    chk("unmapped rresp", 32'(eag_pkg::RESP_SLVERR), 32'(rs));
    chk("unmapped rdata", 32'h0, rd);
    wr(8'h60, 32'h5, eag_pkg::RESP_SLVERR);
    wr(8'h21, 32'h5, eag_pkg::RESP_SLVERR);
    wr(A_ST, 32'hff, OK);
    rdr(A_ST, rd, rs);
    chk("status read only", 32'h0, rd & 32'hff);
    for (int i = 0; i < 8; i++) wr(8'(eag_pkg::OFF_GPR) + 8'(4 * i), g[i], OK);
    for (int s = 0; s < 6; s++) wr(8'(eag_pkg::OFF_SEG) + 8'(4 * s), sg[s], OK);
    rchk(8'(eag_pkg::OFF_GPR) + 8'h1c, g[7], "gpr7");
    for (int k = 0; k < 4; k++) begin
      e = g[3] + (g[1] << k) + 32'h40;
      c = cw(4'h2, 3'h4, 4'h0, 4'h7, 4'h3, 2'(k), 2'h2);
      run(c, 32'h40, e, 3'h3, e, 2'h3);
    end
    c = cw(4'h2, 3'h4, 4'h0, 4'h0, 4'h0, 2'h0, 2'h2);
    run(c, 32'h1234_5678, 32'h1234_5678, 3'h3, 32'h1234_5678, 2'h3);
    c = cw(4'h2, 3'h4, 4'h0, 4'h7, 4'h0, 2'h0, 2'h1);
    run(c, 32'h80, g[3] - 32'h80, 3'h3, g[3] - 32'h80, 2'h3);
    c = cw(4'h2, 3'h4, 4'h0, 4'h7, 4'h0, 2'h0, 2'h0);
    run(c, 32'h80, g[3], 3'h3, g[3], 2'h3);
    c = cw(4'h2, 3'h4, 4'h0, 4'h0, 4'h5, 2'h3, 2'h1);
    run(c, 32'h7f, g[2] * 8 + 32'h7f, 3'h3, g[2] * 8 + 32'h7f, 2'h3);
    c = cw(4'h2, 3'h4, 4'h0, 4'h7, 4'h3, 2'h0, 2'h0);
    run(c, 32'h55, g[3] + g[1], 3'h3, g[3] + g[1], 2'h3);
    c = cw(4'h2, 3'h4, 4'h0, 4'h7, 4'h9, 2'h1, 2'h0);
    run(c, 32'h0, g[3], 3'h3, g[3], 2'h3);
    c = cw(4'h2, 3'h4, 4'h0, 4'h0, 4'h9, 2'h1, 2'h0);
    run(c, 32'h0, 32'h0, 3'h3, 32'h0, 2'h3);
    for (int s = 0; s < 6; s++) begin
      c = cw(4'h2, 3'h4, {3'(s), 1'b1}, 4'h7, 4'h0, 2'h0, 2'h0);
      run(c, 32'h0, g[3], 3'(s), g[3], 2'h3);
    end
    for (int b = 4; b < 6; b++) begin
      c = cw(4'h2, 3'h4, 4'h0, {3'(b), 1'b1}, 4'h0, 2'h0, 2'h0);
      run(c, 32'h0, g[b], 3'h2, g[b], 2'h3);
    end
    c = cw(4'h2, 3'h4, 4'hd, 4'h7, 4'h0, 2'h0, 2'h0);
    run(c, 32'h0, g[3], 3'h3, g[3], 2'h3);
    c = cw(4'h2, 3'h4, 4'h7, 4'hb, 4'h0, 2'h0, 2'h0);
    run(c, 32'h0, g[5], 3'h3, g[5], 2'h3);
    for (int k = 0; k < 4; k++) begin
      c = cw(4'h2, 3'(k), 4'h9, 4'h7, 4'h0, 2'h0, 2'h0);
      run(c, 32'h0, g[3], k == 0 ? 3'h1 : k == 3 ? 3'h0 : 3'h2, g[3], 2'h3);
    end
    c = cw(4'h0, 3'h4, 4'h0, 4'h1, 4'h1, 2'h3, 2'h2);
    run(c, 32'h0001_7000, 32'h0999, 3'h3, 32'h0999, 2'h3);
    c = cw(4'h0, 3'h4, 4'h0, 4'h3, 4'h3, 2'h0, 2'h0);
    run(c, 32'h0, 32'h0ff1, 3'h2, 32'h0ff1, 2'h3);
    for (int m = 0; m < 8; m++) begin
      c = cw({m[2], m[1], m[0], 1'b0}, 3'h4, 4'h0, 4'hd, 4'h0, 2'h0, 2'h0);
      e = (m[0] ^ m[2]) ? g[6] : {16'h0, g[3][15:0]};
      run(c, 32'h0, e, 3'h3, (m[0] ^ m[1]) ? e : e & 32'hffff, 2'h3);
    end
    c = cw(4'h3, 3'h4, 4'h0, 4'h1, 4'h1, 2'h0, 2'h0);
    run(c, 32'h0, 32'h9999, 3'h3, 32'h9999, 2'h3);
    c = cw(4'h9, 3'h4, 4'h0, 4'h0, 4'h0, 2'h0, 2'h2);
    run(c, 32'hffff, 32'hffff, 3'h3, 32'hffff, 2'h3);
    run(c, 32'h1_0000, 32'h1_0000, 3'h3, 32'h0, 2'h1);
    c = cw(4'h1, 3'h4, 4'h0, 4'h1, 4'h0, 2'h0, 2'h2);
    run(c, 32'hffff, 32'h3332, 3'h3, 32'h3332, 2'h3);
    c = cw(4'h2, 3'h4, 4'h0, 4'h5, 4'h0, 2'h0, 2'h0) | OPREG;
    run(c, 32'h0, 32'h0, 3'h0, g[2], 2'h2);
    c = cw(4'h0, 3'h4, 4'h0, 4'h5, 4'h0, 2'h0, 2'h0) | OPREG;
    run(c, 32'h0, 32'h0, 3'h0, g[2] & 32'hffff, 2'h2);
    c = cw(4'h2, 3'h4, 4'h0, 4'hf, 4'h0, 2'h0, 2'h0) | OPREG | BYT;
    run(c, 32'h0, 32'h0, 3'h0, 32'h9c, 2'h2);
    run(c | SGN, 32'h0, 32'h0, 3'h0, 32'hffff_ff9c, 2'h2);
    c = cw(4'h2, 3'h4, 4'h0, 4'h0, 4'h0, 2'h0, 2'h0) | OPIMM;
    run(c, 32'h8001_2345, 32'h0, 3'h0, 32'h8001_2345, 2'h2);
    c = cw(4'h0, 3'h4, 4'h0, 4'h0, 4'h0, 2'h0, 2'h0) | OPIMM;
    run(c, 32'h8001_2345, 32'h0, 3'h0, 32'h2345, 2'h2);
    c = cw(4'h0, 3'h4, 4'h9, 4'h1, 4'h0, 2'h0, 2'h0) | FAR;
    run(c, 32'h0, 32'h3333, 3'h4, {sg[4][15:0], 16'h3333}, 2'h3);
    c = cw(4'h2, 3'h4, 4'h0, 4'h7, 4'h0, 2'h0, 2'h0) | FAR;
    run(c, 32'h0, g[3], 3'h3, g[3], 2'h3);
    rchk(8'(eag_pkg::OFF_CTRL), c, "ctrl");
    for (int t = 0; t < 4; t++) begin
      wr(8'(eag_pkg::OFF_DTYPE), dt[t], OK);
      rdr(A_ST, rd, rs);
      chk("dtype flags", {29'h0, dx[t]}, {29'h0, rd[10:8]});
    end
    ws = 4'h3;
    wr(8'(eag_pkg::OFF_DISP), 32'hffff_ffff, OK);
    ws = 4'hf;
    rchk(8'(eag_pkg::OFF_DISP), 32'h0000_ffff, "disp strobe");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
